// ---- src/clk_ctrl_top.sv ----
`timescale 1ns/1ps
// Overview of operation
// R1 - 6-bit signed rc trim code, +0.375% steps up to 011111, down to 100000
// R2 - trim and auxiliary control registers clear only on power-on reset
// R3 - aux pll enable bit 15 drives pll; bit 14 reads lock state
// R4 - bit 13 picks aux divider source: 1 aux oscillator, 0 primary pll vco
// R5 - aux postscale codes 111..001 divide 1..64, 000 divides by 256
// R6 - software sets postscale to divide-by-1 before using the pwm
// R7 - reference source bit 7: 1 primary oscillator, 0 no input
// R8 - rc-select bit 6 feeds aux pll from rc, else bit 7 decides
// R9 - reference pin driven only while output enable bit 15 set
// R10 - run-in-sleep bit 13 keeps reference running during sleep, else stops
// R11 - source bit 12: 1 crystal oscillator, 0 system clock
// R12 - reference divided by two to the 4-bit code, up to 32768
// R13 - software disables reference output before changing divider code
// R14 - 15-bit pseudo-random value, bit 15 reads zero, cleared at reset
// R15 - switching allowed only when config bit is 0; 1 disables switching and monitor
// R16 - with switching disabled new select ignored, current shows config source; code still takes new select writes
// R17 - with switching disabled request bit held zero, writes ignored
// R18 - switching into and out of primary allowed; submode fixed at run time
// R19 - unimplemented bits read zero
// R20 - pseudo-random register steps on pwm clock, read-only to software
// R21 - request naming the source in use is cleared and aborted
// R22 - valid switch waits 10 new-source cycles, clears request, copies selection

module clk_ctrl_top
  import clk_ctrl_pkg::*;
(
  input  wire logic              CORE_CLK,            // core clock, 100 MHz
  input  wire logic              NRST,                // power-on reset, active low
  input  wire logic              WARM_RST,            // other reset types, sync, active high
  input  wire logic [ADDR_W-1:0] ADDR,                // register index
  input  wire logic [DATA_W-1:0] WR_DATA,             // write data
  input  wire logic              WR_EN,               // write strobe
  input  wire logic              RD_EN,               // read strobe
  output logic      [DATA_W-1:0] RD_DATA,             // read data, cycle after strobe
  input  wire logic              SLEEP,               // device in sleep
  input  wire logic              XTAL_TICK,           // crystal oscillator tick
  input  wire logic              AUX_SRC_TICK,        // tick of selected aux divider source
  input  wire logic              AUX_PLL_LOCK,        // aux pll lock from analog
  input  wire logic              PWM_TICK,            // pwm clock tick
  input  wire logic              NEW_SRC_TICK,        // tick of the requested new source
  input  wire logic              SWITCH_EN_CFG,       // switch enable config bit, 0 enables
  input  wire logic [2:0]        INITIAL_SOURCE_CFG,  // source chosen by configuration
  input  wire logic [1:0]        PRIMARY_SUBMODE_CFG, // primary submode configuration
  output logic      [TRIM_W-1:0] RC_TRIM_CODE,        // rc oscillator trim
  output logic                   AUX_PLL_ENABLE,      // aux pll on
  output logic                   AUX_DIV_SOURCE_SEL,  // 1 aux oscillator, 0 primary vco
  output logic      [1:0]        AUX_PLL_IN_SEL,      // aux pll input selection
  output logic                   AUX_CLK_TICK,        // postscaled aux tick
  output logic                   REF_CLK_PIN,         // reference clock tick out
  output logic                   REF_CLK_PIN_OE_N,    // pin enable, low while driven
  output logic      [2:0]        CURRENT_SOURCE,      // current oscillator
  output logic                   SWITCH_BUSY,         // switch request pending
  output logic                   FAILSAFE_MON_EN,     // failsafe monitor allowed
  output logic      [1:0]        PRIMARY_SUBMODE      // latched primary submode
);

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [TRIM_W-1:0] trim;
  aux_ctrl_t         aux;
  ref_ctrl_t         refc;
  logic [PRNG_W-1:0] prng;
  logic [2:0]        new_src;
  logic [2:0]        cur_src;
  logic              req;
  logic              started;
  sw_state_t         sw_state;
  logic [3:0]        sw_cnt;
  logic [7:0]        aux_cnt;
  logic [14:0]       ref_cnt;
  logic              switch_en;
  logic [7:0]        aux_mask;
  logic [14:0]       ref_mask;
  logic              ref_running;
  logic              ref_src_tick;
  logic [DATA_W-1:0] next_rd_data;

  wire wr_trim = WR_EN && (ADDR == ADDR_TRIM);
  wire wr_aux  = WR_EN && (ADDR == ADDR_AUX);
  wire wr_ref  = WR_EN && (ADDR == ADDR_REF);
  wire wr_osc  = WR_EN && (ADDR == ADDR_OSC);

  assign switch_en = !SWITCH_EN_CFG; // [R15]

  // code to power of two: 111 -> 0 ... 001 -> 6, 000 -> 8
  function automatic logic [3:0] post_shift(input logic [2:0] code);
    post_shift = (code == 3'h0) ? 4'h8 : 4'(3'h7 - code);
  endfunction

  // ****************************************************************
  // power-on-only registers
  // ****************************************************************
  // warm reset deliberately not looked at here
  always_ff @(posedge CORE_CLK or negedge NRST) begin // [R2]
    if (!NRST) begin
      trim <= '0;
    end else if (wr_trim) begin
      trim <= WR_DATA[TRIM_W-1:0]; // [R1]
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin // [R2]
    if (!NRST) begin
      aux <= '{pll_enable: 1'h0, divider_source_select: AUX_DIVSRC_RST, postscale_code: AUX_POST_RST,
               reference_source_select: 1'h0, pll_rc_select: 1'h0};
    end else if (wr_aux) begin
      aux.pll_enable              <= WR_DATA[AUX_EN_BIT];     // [R3]
      aux.divider_source_select   <= WR_DATA[AUX_DIVSRC_BIT]; // [R4]
      aux.postscale_code          <= WR_DATA[AUX_POST_LSB +: 3];
      aux.reference_source_select <= WR_DATA[AUX_REFSRC_BIT];
      aux.pll_rc_select           <= WR_DATA[AUX_RCSEL_BIT];
    end
  end

  // ****************************************************************
  // reference and pseudo-random registers, cleared by any reset
  // ****************************************************************
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      refc <= '0;
    end else if (WARM_RST) begin
      refc <= '0;
    end else if (wr_ref) begin
      refc.output_enable <= WR_DATA[REF_OE_BIT];
      refc.run_in_sleep  <= WR_DATA[REF_SLP_BIT];
      refc.source_select <= WR_DATA[REF_SRC_BIT];
      // divider change while enabled is the user's fault; accepted as written
      refc.divider_code  <= WR_DATA[REF_DIV_LSB +: 4]; // [R13]
    end
  end

  // xnor feedback so the all-zero reset state is not a lock-up state
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      prng <= '0; // [R14]
    end else if (WARM_RST) begin
      prng <= '0; // [R14]
    end else if (PWM_TICK) begin
      prng <= {prng[PRNG_W-2:0], ~(prng[14] ^ prng[13])}; // [R20]
    end
  end

  // ****************************************************************
  // auxiliary clock path
  // ****************************************************************
  assign aux_mask = 8'((9'h1 << post_shift(aux.postscale_code)) - 9'h1);

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      aux_cnt      <= '0;
      AUX_CLK_TICK <= 1'h0;
    end else begin
      if (AUX_SRC_TICK) begin
        aux_cnt <= aux_cnt + 8'h1;
      end
      AUX_CLK_TICK <= AUX_SRC_TICK && ((aux_cnt & aux_mask) == aux_mask); // [R5]
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      AUX_PLL_ENABLE     <= 1'h0;
      AUX_DIV_SOURCE_SEL <= AUX_DIVSRC_RST;
      AUX_PLL_IN_SEL     <= PLL_IN_NONE;
    end else begin
      AUX_PLL_ENABLE     <= aux.pll_enable;            // [R3]
      AUX_DIV_SOURCE_SEL <= aux.divider_source_select; // [R4]
      if (aux.pll_rc_select) begin
        AUX_PLL_IN_SEL <= PLL_IN_RC; // [R8]
      end else if (aux.reference_source_select) begin
        AUX_PLL_IN_SEL <= PLL_IN_PRIMARY; // [R7]
      end else begin
        AUX_PLL_IN_SEL <= PLL_IN_NONE; // [R7]
      end
    end
  end

  // ****************************************************************
  // reference clock output
  // ****************************************************************
  assign ref_src_tick = refc.source_select ? XTAL_TICK : 1'h1; // [R11]
  assign ref_running  = refc.output_enable && (!SLEEP || refc.run_in_sleep); // [R10]
  assign ref_mask     = 15'((16'h1 << refc.divider_code) - 16'h1);

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      ref_cnt          <= '0;
      REF_CLK_PIN      <= 1'h0;
      REF_CLK_PIN_OE_N <= 1'h1;
    end else begin
      if (!ref_running) begin
        ref_cnt <= '0;
      end else if (ref_src_tick) begin
        ref_cnt <= ref_cnt + 15'h1;
      end
      REF_CLK_PIN      <= ref_running && ref_src_tick && ((ref_cnt & ref_mask) == ref_mask); // [R12]
      REF_CLK_PIN_OE_N <= !refc.output_enable; // [R9]
    end
  end

  // ****************************************************************
  // clock switch control
  // ****************************************************************
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      started         <= 1'h0;
      PRIMARY_SUBMODE <= '0;
      FAILSAFE_MON_EN <= 1'h0;
    end else begin
      started         <= 1'h1;
      FAILSAFE_MON_EN <= switch_en; // [R15]
      if (!started) begin
        PRIMARY_SUBMODE <= PRIMARY_SUBMODE_CFG; // [R18]
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      new_src <= '0;
    end else if (!started) begin
      new_src <= INITIAL_SOURCE_CFG;
    end else if (wr_osc && sw_state == SW_IDLE) begin
      new_src <= WR_DATA[OSC_NEW_LSB +: 3];
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      sw_state <= SW_IDLE;
      sw_cnt   <= '0;
      req      <= 1'h0;
      cur_src  <= '0;
    end else if (!started || !switch_en) begin
      sw_state <= SW_IDLE;
      sw_cnt   <= '0;
      req      <= 1'h0;                // [R17]
      cur_src  <= INITIAL_SOURCE_CFG; // [R16]
    end else begin
      unique case (sw_state)
        SW_IDLE: begin
          if (wr_osc && WR_DATA[OSC_REQ_BIT]) begin
            req      <= 1'h1;
            sw_state <= SW_CHECK;
          end
        end
        SW_CHECK: begin
          sw_cnt <= '0;
          if (new_src == cur_src) begin
            req      <= 1'h0; // [R21]
            sw_state <= SW_IDLE;
          end else begin
            sw_state <= SW_WAIT; // [R18]
          end
        end
        SW_WAIT: begin
          if (NEW_SRC_TICK) begin
            if (sw_cnt == SWITCH_WAIT_CYC - 4'h1) begin
              cur_src  <= new_src; // [R22]
              req      <= 1'h0;    // [R22]
              sw_state <= SW_IDLE;
            end else begin
              sw_cnt <= sw_cnt + 4'h1;
            end
          end
        end
        default: begin
          sw_state <= SW_IDLE;
          req      <= 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      CURRENT_SOURCE <= '0;
      SWITCH_BUSY    <= 1'h0;
    end else begin
      CURRENT_SOURCE <= cur_src;
      SWITCH_BUSY    <= req;
    end
  end

  assign RC_TRIM_CODE = trim;

  // ****************************************************************
  // read port
  // ****************************************************************
  always_comb begin
    next_rd_data = '0; // [R19]
    unique case (ADDR)
      ADDR_TRIM: next_rd_data[TRIM_W-1:0] = trim;
      ADDR_AUX: begin
        next_rd_data[AUX_EN_BIT]         = aux.pll_enable;
        next_rd_data[AUX_LOCK_BIT]       = AUX_PLL_LOCK; // [R3]
        next_rd_data[AUX_DIVSRC_BIT]     = aux.divider_source_select;
        next_rd_data[AUX_POST_LSB +: 3]  = aux.postscale_code;
        next_rd_data[AUX_REFSRC_BIT]     = aux.reference_source_select;
        next_rd_data[AUX_RCSEL_BIT]      = aux.pll_rc_select;
      end
      ADDR_REF: begin
        next_rd_data[REF_OE_BIT]         = refc.output_enable;
        next_rd_data[REF_SLP_BIT]        = refc.run_in_sleep;
        next_rd_data[REF_SRC_BIT]        = refc.source_select;
        next_rd_data[REF_DIV_LSB +: 4]   = refc.divider_code;
      end
      ADDR_PRNG: next_rd_data[PRNG_W-1:0] = prng; // [R14]
      ADDR_OSC: begin
        next_rd_data[OSC_CUR_LSB +: 3]   = cur_src;
        next_rd_data[OSC_NEW_LSB +: 3]   = new_src;
        next_rd_data[OSC_REQ_BIT]        = req;
      end
      default: next_rd_data = '0; // [R19]
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      RD_DATA <= '0;
    end else if (RD_EN) begin
      RD_DATA <= next_rd_data;
    end else begin
      RD_DATA <= '0;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  AST_TRIM_WRITE: assert property (wr_trim |=> ##1 RC_TRIM_CODE == $past(WR_DATA[5:0], 2)) // [R1]
    else $error("trim code not taken from write");
  AST_AUX_WARM_KEEP: assert property (WARM_RST && !wr_aux && !wr_trim |=> $stable(aux) && $stable(trim)) // [R2]
    else $error("power-on-only register changed on warm reset");
  AST_PLL_ENABLE: assert property (wr_aux |=> ##1 AUX_PLL_ENABLE == $past(WR_DATA[15], 2)) // [R3]
    else $error("aux pll enable does not follow bit 15");
  AST_LOCK_READ: assert property (RD_EN && ADDR == ADDR_AUX |=> RD_DATA[14] == $past(AUX_PLL_LOCK)) // [R3]
    else $error("lock status bit wrong");
  AST_PLL_INPUT: assert property (aux.pll_rc_select |=> AUX_PLL_IN_SEL == PLL_IN_RC) // [R8]
    else $error("aux pll not fed from rc oscillator");
  AST_NO_INPUT: assert property (!aux.pll_rc_select && !aux.reference_source_select
                                 |=> AUX_PLL_IN_SEL == PLL_IN_NONE) // [R7]
    else $error("aux pll input should be none");
  AST_POST_DIV1: assert property (aux.postscale_code == 3'h7 && AUX_SRC_TICK |=> AUX_CLK_TICK) // [R5]
    else $error("divide-by-1 postscale lost a tick");
  AST_REF_OFF: assert property (!refc.output_enable |=> !REF_CLK_PIN && REF_CLK_PIN_OE_N) // [R9]
    else $error("reference pin active while disabled");
  AST_REF_SLEEP: assert property (SLEEP && !refc.run_in_sleep |=> !REF_CLK_PIN) // [R10]
    else $error("reference output ran in sleep");
  AST_REF_UNDIV: assert property (refc.output_enable && !SLEEP && !refc.source_select
                                  && refc.divider_code == 4'h0 |=> REF_CLK_PIN) // [R12]
    else $error("undivided system reference missed a cycle");
  AST_PRNG_TOP: assert property (RD_EN && ADDR == ADDR_PRNG |=> RD_DATA[15] == 1'h0) // [R14]
    else $error("pseudo-random bit 15 not zero");
  AST_REQ_HELD: assert property (!switch_en |=> !req ##1 !SWITCH_BUSY) // [R17]
    else $error("switch request set while switching disabled");
  AST_CUR_CFG: assert property (started && !switch_en |=> cur_src == $past(INITIAL_SOURCE_CFG)) // [R16]
    else $error("current source does not follow configuration");
  AST_ABORT: assert property (sw_state == SW_CHECK && new_src == cur_src && switch_en
                              |=> !req && $stable(cur_src)) // [R21]
    else $error("redundant switch not aborted");
  AST_SWITCH_DONE: assert property (sw_state == SW_WAIT && NEW_SRC_TICK && sw_cnt == 4'h9 && switch_en
                                    |=> !req && cur_src == $past(new_src)) // [R22]
    else $error("switch did not complete after ten source cycles");
  AST_MONITOR: assert property (SWITCH_EN_CFG |=> !FAILSAFE_MON_EN) // [R15]
    else $error("failsafe monitor enabled with switching disabled");
  AST_UNMAPPED: assert property (RD_EN && ADDR > ADDR_OSC |=> RD_DATA == '0) // [R19]
    else $error("unmapped read not zero");

  CVR_SWITCH: cover property (sw_state == SW_WAIT ##1 sw_state == SW_IDLE && !req);
  CVR_ABORT: cover property (sw_state == SW_CHECK ##1 sw_state == SW_IDLE);
  CVR_REF_DIV: cover property (REF_CLK_PIN && refc.divider_code == 4'h2);
  CVR_AUX_256: cover property (AUX_CLK_TICK && aux.postscale_code == 3'h0);

endmodule // clk_ctrl_top

// ---- src/clk_ctrl_pkg.sv ----
package clk_ctrl_pkg;

  // ****************************************************************
  // register port and map
  // ****************************************************************
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 3;

  localparam logic [ADDR_W-1:0] ADDR_TRIM = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_AUX  = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_REF  = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_PRNG = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_OSC  = 3'h4;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned TRIM_W          = 6;
  localparam int unsigned AUX_EN_BIT      = 15;
  localparam int unsigned AUX_LOCK_BIT    = 14;
  localparam int unsigned AUX_DIVSRC_BIT  = 13;
  localparam int unsigned AUX_POST_LSB    = 8;
  localparam int unsigned AUX_REFSRC_BIT  = 7;
  localparam int unsigned AUX_RCSEL_BIT   = 6;
  localparam int unsigned REF_OE_BIT      = 15;
  localparam int unsigned REF_SLP_BIT     = 13;
  localparam int unsigned REF_SRC_BIT     = 12;
  localparam int unsigned REF_DIV_LSB     = 8;
  localparam int unsigned PRNG_W          = 15;
  localparam int unsigned OSC_CUR_LSB     = 12;
  localparam int unsigned OSC_NEW_LSB     = 8;
  localparam int unsigned OSC_REQ_BIT     = 0;

  // ****************************************************************
  // reset values and counts
  // ****************************************************************
  localparam logic [2:0] AUX_POST_RST    = 3'h7;
  localparam logic       AUX_DIVSRC_RST  = 1'h1;
  localparam logic [3:0] SWITCH_WAIT_CYC = 4'ha;

  typedef struct packed {
    logic       pll_enable;
    logic       divider_source_select;
    logic [2:0] postscale_code;
    logic       reference_source_select;
    logic       pll_rc_select;
  } aux_ctrl_t;

  typedef struct packed {
    logic       output_enable;
    logic       run_in_sleep;
    logic       source_select;
    logic [3:0] divider_code;
  } ref_ctrl_t;

  typedef enum logic [1:0] {
    PLL_IN_NONE    = 2'b00,
    PLL_IN_PRIMARY = 2'b01,
    PLL_IN_RC      = 2'b10
  } pll_in_t;

  typedef enum logic [1:0] {
    SW_IDLE  = 2'b00,
    SW_CHECK = 2'b01,
    SW_WAIT  = 2'b10
  } sw_state_t;

endpackage

// ---- dv/aux_ref_clock_and_switch_gate_tb.sv ----
`timescale 1ns/1ps
module aux_ref_clock_and_switch_gate_tb;
  import clk_ctrl_pkg::*;

  // ****************************************************************
  // stimulus, observed outputs and bookkeeping
  // ****************************************************************
  logic              core_clk, nrst, warm_rst, wr_en, rd_en, sleep, xtal_tick, xtal_run;
  logic              aux_src_tick, aux_pll_lock, pwm_tick, new_src_tick, switch_en_cfg;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data, rd_data;
  logic [2:0]        init_src_cfg, current_source;
  logic [1:0]        submode_cfg, aux_pll_in_sel, primary_submode;
  logic [TRIM_W-1:0] rc_trim_code;
  logic              aux_pll_enable, aux_div_source_sel, aux_clk_tick, ref_clk_pin;
  logic              ref_clk_pin_oe_n, switch_busy, failsafe_mon_en;
  logic [14:0]       pseudo_random_shift_value_exp;
  int                err_total, total_checks, aux_cnt, ref_cnt;

  clk_ctrl_top i_dut (
    .CORE_CLK(core_clk), .NRST(nrst), .WARM_RST(warm_rst), .ADDR(addr), .WR_DATA(wr_data),
    .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data), .SLEEP(sleep), .XTAL_TICK(xtal_tick),
    .AUX_SRC_TICK(aux_src_tick), .AUX_PLL_LOCK(aux_pll_lock), .PWM_TICK(pwm_tick),
    .NEW_SRC_TICK(new_src_tick), .SWITCH_EN_CFG(switch_en_cfg), .INITIAL_SOURCE_CFG(init_src_cfg),
    .PRIMARY_SUBMODE_CFG(submode_cfg), .RC_TRIM_CODE(rc_trim_code), .AUX_PLL_ENABLE(aux_pll_enable),
    .AUX_DIV_SOURCE_SEL(aux_div_source_sel), .AUX_PLL_IN_SEL(aux_pll_in_sel), .AUX_CLK_TICK(aux_clk_tick),
    .REF_CLK_PIN(ref_clk_pin), .REF_CLK_PIN_OE_N(ref_clk_pin_oe_n), .CURRENT_SOURCE(current_source),
    .SWITCH_BUSY(switch_busy), .FAILSAFE_MON_EN(failsafe_mon_en), .PRIMARY_SUBMODE(primary_submode)
  );

  always #5 core_clk = ~core_clk;

  // crystal ticks every other core cycle, so its rate differs from the system source
  always @(posedge core_clk) xtal_tick <= xtal_run & ~xtal_tick;

  always @(posedge core_clk) begin
    if (aux_clk_tick === 1'b1) aux_cnt++;
    if (ref_clk_pin === 1'b1) ref_cnt++;
  end

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] m);
    @(posedge core_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 chk(rd_data & m, e);
  endtask

  task automatic por();
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic new_ticks(input int n);
    @(posedge core_clk);
    new_src_tick <= 1'b1;
    repeat (n) @(posedge core_clk);
    new_src_tick <= 1'b0;
    cyc(3);
  endtask

  // divider code is written while the output is off, then the output runs for 64 cycles
  task automatic ref_run(input logic [15:0] ctl, input int exp);
    wr(ADDR_REF, ctl);
    cyc(1);
    ref_cnt = 0;
    wr(ADDR_REF, ctl | 16'h8000);
    cyc(31);
    chk(ref_clk_pin_oe_n, 1'b0);
    repeat (31) @(posedge core_clk);
    wr(ADDR_REF, ctl);
    cyc(4);
    chk(ref_clk_pin_oe_n, 1'b1);
    chk(ref_cnt[15:0], exp[15:0]);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #500000;
    err_total++;
    test_done();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    core_clk = 1'b0; nrst = 1'b0; warm_rst = 1'b0; wr_en = 1'b0; rd_en = 1'b0; sleep = 1'b0;
    xtal_tick = 1'b0; xtal_run = 1'b0; aux_src_tick = 1'b0; aux_pll_lock = 1'b0; pwm_tick = 1'b0;
    new_src_tick = 1'b0; switch_en_cfg = 1'b0; addr = 3'h0; wr_data = 16'h0000;
    init_src_cfg = 3'h2; submode_cfg = 2'h1; err_total = 0; total_checks = 0; aux_cnt = 0; ref_cnt = 0;
    por();
    rc(ADDR_TRIM, 16'h0000, 16'hffff);
    rc(ADDR_AUX, 16'h2700, 16'hffff);
    rc(ADDR_REF, 16'h0000, 16'hffff);
    rc(ADDR_PRNG, 16'h0000, 16'hffff);
    rc(ADDR_OSC, 16'h2000, 16'h7001);
    rc(3'h5, 16'h0000, 16'hffff);
    wr(ADDR_TRIM, 16'hffdf);
    cyc(2);
    rc(ADDR_TRIM, 16'h001f, 16'hffff);
    chk(rc_trim_code, 6'h1f);
    wr(ADDR_TRIM, 16'h0020);
    cyc(2);
    chk(rc_trim_code, 6'h20);
    wr(ADDR_AUX, 16'hffff);
    cyc(2);
    rc(ADDR_AUX, 16'ha7c0, 16'hffff);
    chk(aux_pll_enable, 1'b1);
    chk(aux_div_source_sel, 1'b1);
    chk(aux_pll_in_sel, 2'b10);
    @(posedge core_clk);
    aux_pll_lock <= 1'b1;
    wr(ADDR_AUX, 16'h0080);
    cyc(2);
    chk(aux_pll_in_sel, 2'b01);
    chk(aux_div_source_sel, 1'b0);
    chk(aux_pll_enable, 1'b0);
    wr(ADDR_AUX, 16'h0000);
    cyc(2);
    chk(aux_pll_in_sel, 2'b00);
    rc(ADDR_AUX, 16'h4000, 16'hffff);
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_AUX, 16'h2000 | (16'(c) << 8));
      cyc(1);
      aux_cnt = 0;
      @(posedge core_clk);
      aux_src_tick <= 1'b1;
      repeat (512) @(posedge core_clk);
      aux_src_tick <= 1'b0;
      cyc(4);
      chk(aux_cnt[15:0], 16'(512 / ((c == 0) ? 256 : (1 << (7 - c)))));
    end
    for (int c = 0; c < 6; c++) ref_run(16'(c) << 8, 64 >> c);
    xtal_run = 1'b1;
    ref_run(16'h1100, 16);
    xtal_run = 1'b0;
    @(posedge core_clk);
    sleep <= 1'b1;
    ref_run(16'h0100, 0);
    ref_run(16'h2100, 32);
    @(posedge core_clk);
    sleep <= 1'b0;
    rc(ADDR_AUX, 16'h0700, 16'h0700);
    pseudo_random_shift_value_exp = 15'h0000;
    @(posedge core_clk);
    pwm_tick <= 1'b1;
    repeat (20) @(posedge core_clk);
    pwm_tick <= 1'b0;
    repeat (20) pseudo_random_shift_value_exp = {pseudo_random_shift_value_exp[13:0], ~(pseudo_random_shift_value_exp[14] ^ pseudo_random_shift_value_exp[13])};
    wr(ADDR_PRNG, 16'h1234);
    rc(ADDR_PRNG, {1'b0, pseudo_random_shift_value_exp}, 16'hffff);
    @(posedge core_clk);
    warm_rst <= 1'b1;
    @(posedge core_clk);
    warm_rst <= 1'b0;
    cyc(1);
    rc(ADDR_PRNG, 16'h0000, 16'hffff);
    rc(ADDR_TRIM, 16'h0020, 16'hffff);
    rc(ADDR_AUX, 16'h6700, 16'hffff);
    chk(failsafe_mon_en, 1'b1);
    wr(ADDR_OSC, 16'h0200);
    wr(ADDR_OSC, 16'h0201);
    cyc(3);
    rc(ADDR_OSC, 16'h2200, 16'h7701);
    chk(switch_busy, 1'b0);
    wr(ADDR_OSC, 16'h0000);
    wr(ADDR_OSC, 16'h0001);
    cyc(2);
    chk(switch_busy, 1'b1);
    submode_cfg = 2'h3;
    new_ticks(9);
    chk(switch_busy, 1'b1);
    chk(current_source, 3'h2);
    new_ticks(1);
    chk(switch_busy, 1'b0);
    chk(current_source, 3'h0);
    rc(ADDR_OSC, 16'h0000, 16'h7001);
    wr(ADDR_OSC, 16'h0200);
    wr(ADDR_OSC, 16'h0201);
    new_ticks(12);
    chk(current_source, 3'h2);
    chk(primary_submode, 2'h1);
    @(posedge core_clk);
    switch_en_cfg <= 1'b1;
    init_src_cfg  <= 3'h7;
    por();
    rc(ADDR_TRIM, 16'h0000, 16'hffff);
    chk(failsafe_mon_en, 1'b0);
    wr(ADDR_OSC, 16'h0301);
    cyc(2);
    chk(switch_busy, 1'b0);
    new_ticks(12);
    rc(ADDR_OSC, 16'h7000, 16'h7001);
    chk(current_source, 3'h7);
    test_done();
  end

endmodule // aux_ref_clock_and_switch_gate_tb
